// [rtl/frpm_pkg.sv]
// Shared constants and types for the fault response and phase mode block.
package frpm_pkg;
  localparam int CLK_NS = 10;
  localparam int T_ON_RISE_NS = 1000;
  localparam int HICCUP_MULT = 7;
  localparam int HICCUP_CYC = HICCUP_MULT * T_ON_RISE_NS / CLK_NS;
  localparam int SW_PERIOD_NS = 2000;
  localparam int SW_DIV_CYC = SW_PERIOD_NS / CLK_NS;
  localparam logic [2:0] OC_TRIP = 3'h7;
  localparam logic [1:0] PWM_TRI = 2'h0;
  localparam logic [1:0] PWM_LOW = 2'h1;
  localparam logic [1:0] PWM_RUN = 2'h2;
  localparam logic [1:0] SS_BEFORE = 2'h0;
  localparam logic [1:0] SS_DURING = 2'h1;
  localparam logic [1:0] SS_AFTER = 2'h2;
  localparam logic [1:0] MODE_DUAL = 2'h0;
  localparam logic [1:0] MODE_TWO = 2'h1;
  localparam logic [1:0] MODE_THREE = 2'h2;
  localparam logic [1:0] MODE_FOUR = 2'h3;
  localparam int HTRANS_ACT_BIT = 1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_MASK = 8'h08;
  localparam logic [7:0] A_VIEW = 8'h0c;
  localparam int EV_OC = 0;
  localparam int EV_VIN = 1;
  localparam int EV_UV = 2;
  localparam int EV_OV = 3;
  localparam int EV_OT = 4;
  localparam int EV_JOT = 5;
  localparam int EV_EXT = 6;
  localparam int EV_W = 7;
  localparam int NCH = 2;
  typedef enum logic [2:0] {
    CH_OFF = 3'b000, CH_RUN = 3'b001, CH_HOLD = 3'b010, CH_LATCH = 3'b011, CH_OVLOW = 3'b100
  } frpm_ch_st_t;
  typedef enum logic [2:0] {
    ROLE_MASTER = 3'b000, ROLE_SLAVE1 = 3'b001, ROLE_SLAVE2 = 3'b010, ROLE_SLAVE3 = 3'b011,
    ROLE_INDEP = 3'b100
  } frpm_role_t;
  typedef struct packed {
    logic dev2;
    logic [1:0] mode;
    logic ov_track;
    logic oc_latch;
    logic [1:0] en;
  } frpm_ctrl_t;
  localparam frpm_ctrl_t CTRL_RST = '0;
  typedef struct packed {
    logic [1:0] fault_line;
    logic [1:0] et_cool;
    logic [1:0] et_hot;
    logic [1:0] fb_over;
    logic [1:0] fb_under;
    logic [1:0] oc_over;
    logic j_cool;
    logic j_hot;
    logic v_off;
    logic v_on;
  } frpm_pins_t;
  typedef struct packed {
    frpm_role_t role1;
    frpm_role_t role0;
    frpm_ch_st_t st1;
    frpm_ch_st_t st0;
    logic [1:0] flt_low;
    logic [1:0] pull;
  } frpm_view_t;
endpackage : frpm_pkg

// [rtl/frpm_chan.sv]
// One channel: fault classification, shutdown response and restart sequencing.
//
// Local design decisions: the placing of the registers and the AHB-Lite register port.
module frpm_chan (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tick,
  input wire logic en,
  input wire logic oc_latch,
  input wire logic ov_track,
  input wire logic vsense_en,
  input wire logic [1:0] ss_phase,
  input wire logic oc_over,
  input wire logic fb_under,
  input wire logic fb_over,
  input wire logic et_hot,
  input wire logic et_cool,
  input wire logic input_on_threshold,
  input wire logic input_off_threshold,
  input wire logic j_hot,
  input wire logic j_cool,
  input wire logic flt_low,
  output logic [1:0] pwm,
  output logic pull,
  output logic ss_start,
  output logic cbc_limit,
  output logic [frpm_pkg::EV_W-1:0] ev,
  output frpm_pkg::frpm_ch_st_t st
);
  localparam logic [9:0] HIC_LAST = 10'(frpm_pkg::HICCUP_CYC - 1);
  typedef struct packed {
    frpm_pkg::frpm_ch_st_t st;
    logic [1:0] pwm;
    logic pull;
    logic ss_start;
    logic cbc;
    logic armed;
    logic w_tmr;
    logic w_ot;
    logic w_jot;
    logic w_vin;
    logic [2:0] oc_cnt;
    logic [9:0] hic;
    logic [frpm_pkg::EV_W-1:0] ev;
  } frpm_cs_t;
  frpm_cs_t r;
  frpm_cs_t n;
  logic after;
  logic oc_f;
  logic uv_f;
  logic ov_f;
  logic vin_f;
  logic own;
  logic waiting;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.ss_start = 1'b0;
    n.ev = '0;
    after = ss_phase == frpm_pkg::SS_AFTER;
    oc_f = tick && oc_over && after && r.oc_cnt == frpm_pkg::OC_TRIP - 3'h1; // [RULE7] [RULE14]
    uv_f = fb_under && after && vsense_en; // [RULE16] [RULE13]
    ov_f = fb_over && vsense_en && (after || !ov_track); // [RULE8]
    vin_f = r.armed && input_off_threshold; // [RULE17]
    own = oc_f || uv_f || vin_f || et_hot || j_hot;
    waiting = r.w_tmr || r.w_ot || r.w_jot || r.w_vin;
    if (input_on_threshold) begin
      n.armed = 1'b1;
    end
    if (tick) begin
      n.oc_cnt = (oc_over && after && r.st == frpm_pkg::CH_RUN) ? r.oc_cnt + 3'h1 : 3'h0;
    end
    case (r.st)
      frpm_pkg::CH_OFF: begin
        if (en && !flt_low) begin
          n.st = frpm_pkg::CH_RUN;
          n.ss_start = 1'b1;
        end
      end
      frpm_pkg::CH_RUN: begin
        if (!en) begin
          n.st = frpm_pkg::CH_OFF;
        end else if (ov_f) begin
          n.st = frpm_pkg::CH_OVLOW; // [RULE8]
          n.ev[frpm_pkg::EV_OV] = 1'b1;
        end else if (own) begin
          n.pull = 1'b1; // [RULE1]
          n.ev[frpm_pkg::EV_OC] = oc_f;
          n.ev[frpm_pkg::EV_UV] = uv_f;
          n.ev[frpm_pkg::EV_VIN] = vin_f;
          n.ev[frpm_pkg::EV_OT] = et_hot;
          n.ev[frpm_pkg::EV_JOT] = j_hot;
          n.w_tmr = (oc_f || uv_f) && !oc_latch; // [RULE6]
          n.w_ot = et_hot; // [RULE9]
          n.w_jot = j_hot; // [RULE18]
          n.w_vin = vin_f; // [RULE17]
          n.hic = '0;
          if (vin_f) begin
            n.armed = 1'b0;
          end
          n.st = ((oc_f || uv_f) && oc_latch) ? frpm_pkg::CH_LATCH : frpm_pkg::CH_HOLD; // [RULE5]
        end else if (flt_low) begin
          n.st = frpm_pkg::CH_HOLD; // [RULE2] [RULE3]
          n.ev[frpm_pkg::EV_EXT] = 1'b1;
        end
      end
      frpm_pkg::CH_HOLD: begin
        if (r.w_tmr) begin
          n.hic = r.hic + 10'h1;
          if (r.hic == HIC_LAST) begin
            n.w_tmr = 1'b0;
          end
        end
        if (et_cool) begin
          n.w_ot = 1'b0;
        end
        if (j_cool) begin
          n.w_jot = 1'b0;
        end
        if (r.armed) begin
          n.w_vin = 1'b0;
        end
        // The line is held only while our own cause lasts, so peers can rejoin.
        n.pull = n.w_tmr || n.w_ot || n.w_jot || n.w_vin;
        if (!en) begin
          n.st = frpm_pkg::CH_OFF;
        end else if (!waiting && !r.pull && !flt_low) begin
          n.st = frpm_pkg::CH_RUN; // [RULE4] [RULE15]
          n.ss_start = 1'b1;
        end
      end
      frpm_pkg::CH_LATCH, frpm_pkg::CH_OVLOW: begin
        if (!en) begin
          n.st = frpm_pkg::CH_OFF;
        end
      end
      default: begin
        n.st = frpm_pkg::CH_OFF;
      end
    endcase
    if (n.st == frpm_pkg::CH_OFF) begin
      n.pull = 1'b0;
      n.w_tmr = 1'b0;
      n.w_ot = 1'b0;
      n.w_jot = 1'b0;
      n.w_vin = 1'b0;
      n.oc_cnt = '0;
    end
    n.pwm = (n.st == frpm_pkg::CH_RUN) ? frpm_pkg::PWM_RUN :
            (n.st == frpm_pkg::CH_OVLOW) ? frpm_pkg::PWM_LOW : frpm_pkg::PWM_TRI;
    n.cbc = n.st == frpm_pkg::CH_RUN && ss_phase == frpm_pkg::SS_DURING && oc_over; // [RULE7]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign pwm = r.pwm;
  assign pull = r.pull;
  assign ss_start = r.ss_start;
  assign cbc_limit = r.cbc;
  assign ev = r.ev;
  assign st = r.st;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_run_own;
    r.st == frpm_pkg::CH_RUN && en && !ov_f && own;
  endsequence
  sequence s_tri_pulled;
    pwm == frpm_pkg::PWM_TRI && pull;
  endsequence
  property p_pull;
    @(posedge hclk) disable iff (!hresetn) s_run_own |=> s_tri_pulled;
  endproperty
  a_pull: assert property (p_pull) else $error("own fault did not pull line"); // [RULE1]
  property p_ext;
    @(posedge hclk) disable iff (!hresetn)
      (r.st == frpm_pkg::CH_RUN && en && !ov_f && !own && flt_low)
      |=> (pwm == frpm_pkg::PWM_TRI && ev[frpm_pkg::EV_EXT]);
  endproperty
  a_ext: assert property (p_ext) else $error("external fault not obeyed"); // [RULE2]
  property p_rejoin;
    @(posedge hclk) disable iff (!hresetn)
      (ss_start && $past(r.st) == frpm_pkg::CH_HOLD) |-> !$past(flt_low) && !$past(pull, 2);
  endproperty
  a_rejoin: assert property (p_rejoin) else $error("restart while line held"); // [RULE4]
  property p_oc_resp;
    @(posedge hclk) disable iff (!hresetn)
      (s_run_own ##0 (oc_f || uv_f)) |=> (st == ($past(oc_latch) ? frpm_pkg::CH_LATCH :
      frpm_pkg::CH_HOLD)) && pwm == frpm_pkg::PWM_TRI;
  endproperty
  a_oc_resp: assert property (p_oc_resp) else $error("wrong current fault response"); // [RULE6]
  property p_oc_gate;
    @(posedge hclk) disable iff (!hresetn)
      ev[frpm_pkg::EV_OC] |-> $past(ss_phase) == frpm_pkg::SS_AFTER && $past(oc_over);
  endproperty
  a_oc_gate: assert property (p_oc_gate) else $error("current fault outside run"); // [RULE7]
  property p_oc_cnt;
    @(posedge hclk) disable iff (!hresetn)
      ev[frpm_pkg::EV_OC] |-> $past(r.oc_cnt) == frpm_pkg::OC_TRIP - 3'h1;
  endproperty
  a_oc_cnt: assert property (p_oc_cnt) else $error("current trip count wrong"); // [RULE14]
  property p_ov;
    @(posedge hclk) disable iff (!hresetn)
      ev[frpm_pkg::EV_OV] |-> (pwm == frpm_pkg::PWM_LOW && !pull)
      && ($past(ss_phase) == frpm_pkg::SS_AFTER || !$past(ov_track));
  endproperty
  a_ov: assert property (p_ov) else $error("overvoltage response wrong"); // [RULE8]
  property p_ot;
    @(posedge hclk) disable iff (!hresetn)
      (r.st == frpm_pkg::CH_HOLD && r.w_ot && !et_cool) |=> st != frpm_pkg::CH_RUN [*2];
  endproperty
  a_ot: assert property (p_ot) else $error("restart while still hot"); // [RULE9]
  property p_uv_gate;
    @(posedge hclk) disable iff (!hresetn)
      ev[frpm_pkg::EV_UV] |-> $past(ss_phase) == frpm_pkg::SS_AFTER && $past(vsense_en);
  endproperty
  a_uv_gate: assert property (p_uv_gate) else $error("undervoltage outside run"); // [RULE16]
  property p_vin;
    @(posedge hclk) disable iff (!hresetn)
      ev[frpm_pkg::EV_VIN] |-> $past(r.armed) && !r.armed && r.w_vin;
  endproperty
  a_vin: assert property (p_vin) else $error("input fault without arming"); // [RULE17]
  property p_jot;
    @(posedge hclk) disable iff (!hresetn)
      (r.st == frpm_pkg::CH_HOLD && r.w_jot && !j_cool) |=> !ss_start && pwm == frpm_pkg::PWM_TRI;
  endproperty
  a_jot: assert property (p_jot) else $error("restart while junction hot"); // [RULE18] [RULE15]
endmodule : frpm_chan

// [rtl/frpm_top.sv]
// Fault response and phase role block with an AHB-Lite register slave.
// Function
// RULE1 - Own faults pull the channel fault line low.
// RULE2 - Externally low fault line shuts channel off.
// RULE3 - Fault on any rail phase stops all.
// RULE4 - Restart only after all phases release line.
// RULE5 - Current above threshold flags fault, PWM tri-state.
// RULE6 - One setting picks latch or hiccup.
// RULE7 - Current fault only after soft-start; limit during.
// RULE8 - Overvoltage drives PWM low, latches; fixed early.
// RULE9 - External overtemperature tri-states, retries when cool.
// RULE10 - Dual masters; two-phase master plus slave.
// RULE11 - Three-phase roles across two devices.
// RULE12 - Four-phase roles across two devices.
// RULE13 - Only master channels sense output voltage; the code also senses on the independent channel (ROLE_INDEP).
// RULE14 - Seven consecutive overcurrents trip, hiccup default.
// RULE15 - Junction cool restarts with fresh soft-start.
// RULE16 - Output undervoltage ignored until soft-start done.
// RULE17 - Input undervoltage needs arming; tri-state, no hiccup.
// RULE18 - Junction overtemperature tri-states in every phase.
module frpm_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [3:0] soft_start_phase,
  input wire logic [1:0] current_sense_over,
  input wire logic [1:0] feedback_input_under,
  input wire logic [1:0] feedback_input_over,
  input wire logic [1:0] ext_temp_sense_input_hot,
  input wire logic [1:0] ext_temp_sense_input_cool,
  input wire logic input_on_threshold_hit,
  input wire logic input_off_threshold_hit,
  input wire logic junction_overtemp_fault,
  input wire logic junction_cool,
  input wire logic [1:0] fault_line_in,
  output logic [1:0] fault_line_out,
  output logic [1:0] fault_line_oe,
  output logic [3:0] pwm_state,
  output logic [1:0] soft_start_req,
  output logic [1:0] cbc_limit,
  output logic irq
);
  localparam int SW = 2 * frpm_pkg::EV_W;
  localparam logic [7:0] DIV_LAST = 8'(frpm_pkg::SW_DIV_CYC - 1);

  typedef struct packed {
    frpm_pkg::frpm_pins_t s1;
    frpm_pkg::frpm_pins_t s2;
    logic [7:0] div;
    logic tick;
    logic a_wr;
    logic [7:0] a_off;
    frpm_pkg::frpm_ctrl_t ctrl;
    logic [SW-1:0] stat;
    logic [SW-1:0] mask;
    logic [31:0] rdata;
    logic irq;
  } frpm_top_st_t;

  frpm_top_st_t r;
  frpm_top_st_t n;
  frpm_pkg::frpm_pins_t pin_raw;
  frpm_pkg::frpm_view_t view;
  frpm_pkg::frpm_role_t role [frpm_pkg::NCH];
  frpm_pkg::frpm_ch_st_t ch_st [frpm_pkg::NCH];
  logic [frpm_pkg::NCH-1:0] vs_en;
  logic [SW-1:0] ev_all;
  logic [SW-1:0] clr;

  // ----------------------------------------------------------------
  // Channel roles
  // ----------------------------------------------------------------
  function automatic frpm_pkg::frpm_role_t role_of(input logic [1:0] mode, input logic dev2,
                                                   input logic ch);
    case (mode)
      frpm_pkg::MODE_TWO: role_of = ch ? frpm_pkg::ROLE_SLAVE1 : frpm_pkg::ROLE_MASTER;
      frpm_pkg::MODE_THREE: begin
        if (dev2) begin
          role_of = ch ? frpm_pkg::ROLE_INDEP : frpm_pkg::ROLE_SLAVE1;
        end else begin
          role_of = ch ? frpm_pkg::ROLE_SLAVE2 : frpm_pkg::ROLE_MASTER;
        end
      end
      frpm_pkg::MODE_FOUR: begin
        if (dev2) begin
          role_of = ch ? frpm_pkg::ROLE_SLAVE3 : frpm_pkg::ROLE_SLAVE1;
        end else begin
          role_of = ch ? frpm_pkg::ROLE_SLAVE2 : frpm_pkg::ROLE_MASTER;
        end
      end
      default: role_of = frpm_pkg::ROLE_MASTER;
    endcase
  endfunction : role_of

  assign role[0] = role_of(r.ctrl.mode, r.ctrl.dev2, 1'b0); // [RULE10] [RULE11] [RULE12]
  assign role[1] = role_of(r.ctrl.mode, r.ctrl.dev2, 1'b1); // [RULE10] [RULE11] [RULE12]

  // Slaves have their feedback tied off, so their output-voltage checks are masked.
  generate
    for (genvar g = 0; g < frpm_pkg::NCH; g++) begin : g_vs
      assign vs_en[g] = role[g] == frpm_pkg::ROLE_MASTER || role[g] == frpm_pkg::ROLE_INDEP; // [RULE13]
    end
  endgenerate

  assign pin_raw = {fault_line_in, ext_temp_sense_input_cool, ext_temp_sense_input_hot,
                    feedback_input_over, feedback_input_under, current_sense_over,
                    junction_cool, junction_overtemp_fault, input_off_threshold_hit,
                    input_on_threshold_hit};
  assign view = {role[1], role[0], ch_st[1], ch_st[0], ~r.s2.fault_line, fault_line_oe};

  // ----------------------------------------------------------------
  // Registers, bus slave, synchronisers and switching-cycle divider
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.s1 = pin_raw;
    n.s2 = r.s1;
    n.tick = 1'b0;
    if (r.div == DIV_LAST) begin
      n.div = '0;
      n.tick = 1'b1;
    end else begin
      n.div = r.div + 8'h1;
    end
    clr = '0;
    if (r.a_wr) begin
      case (r.a_off)
        frpm_pkg::A_CTRL: n.ctrl = hwdata[$bits(frpm_pkg::frpm_ctrl_t)-1:0];
        frpm_pkg::A_STAT: clr = hwdata[SW-1:0];
        frpm_pkg::A_MASK: n.mask = hwdata[SW-1:0];
        default: ;
      endcase
    end
    // A new event in the clearing cycle survives the write-one-to-clear.
    n.stat = (r.stat & ~clr) | ev_all;
    n.irq = |(n.stat & n.mask);
    n.a_wr = 1'b0;
    if (hsel && hready && htrans[frpm_pkg::HTRANS_ACT_BIT]) begin
      n.a_wr = hwrite && hsize == frpm_pkg::HSIZE_WORD;
      n.a_off = haddr[7:0];
      case (haddr[7:0])
        frpm_pkg::A_CTRL: n.rdata = 32'(r.ctrl);
        frpm_pkg::A_STAT: n.rdata = 32'(r.stat);
        frpm_pkg::A_MASK: n.rdata = 32'(r.mask);
        frpm_pkg::A_VIEW: n.rdata = 32'(view);
        default: n.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      // The fault lines idle high, so a zero here would read as a fault just after reset.
      r.s1.fault_line <= '1;
      r.s2.fault_line <= '1;
    end else begin
      r <= n;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r.rdata;
  assign irq = r.irq;
  assign fault_line_out = '0;

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  // Both channels share the one response setting, so a slave follows a master on the same device.
  generate
    for (genvar g = 0; g < frpm_pkg::NCH; g++) begin : g_ch
      frpm_chan u_chan (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(r.tick),
        .en(r.ctrl.en[g]),
        .oc_latch(r.ctrl.oc_latch), // [RULE6]
        .ov_track(r.ctrl.ov_track),
        .vsense_en(vs_en[g]),
        .ss_phase(soft_start_phase[2*g +: 2]),
        .oc_over(r.s2.oc_over[g]),
        .fb_under(r.s2.fb_under[g]),
        .fb_over(r.s2.fb_over[g]),
        .et_hot(r.s2.et_hot[g]),
        .et_cool(r.s2.et_cool[g]),
        .input_on_threshold(r.s2.v_on),
        .input_off_threshold(r.s2.v_off),
        .j_hot(r.s2.j_hot),
        .j_cool(r.s2.j_cool),
        .flt_low(!r.s2.fault_line[g]),
        .pwm(pwm_state[2*g +: 2]),
        .pull(fault_line_oe[g]),
        .ss_start(soft_start_req[g]),
        .cbc_limit(cbc_limit[g]),
        .ev(ev_all[frpm_pkg::EV_W*g +: frpm_pkg::EV_W]),
        .st(ch_st[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_role_two;
    @(posedge hclk) disable iff (!hresetn)
      r.ctrl.mode == frpm_pkg::MODE_TWO |-> role[0] == frpm_pkg::ROLE_MASTER
      && role[1] == frpm_pkg::ROLE_SLAVE1 && vs_en == 2'h1;
  endproperty
  a_role_two: assert property (p_role_two) else $error("two-phase roles wrong"); // [RULE10]
  property p_role_dual;
    @(posedge hclk) disable iff (!hresetn)
      r.ctrl.mode == frpm_pkg::MODE_DUAL |-> vs_en == 2'h3 && role[1] == frpm_pkg::ROLE_MASTER;
  endproperty
  a_role_dual: assert property (p_role_dual) else $error("dual roles wrong"); // [RULE10]
  property p_role_three;
    @(posedge hclk) disable iff (!hresetn)
      (r.ctrl.mode == frpm_pkg::MODE_THREE && r.ctrl.dev2) |-> role[0] == frpm_pkg::ROLE_SLAVE1
      && role[1] == frpm_pkg::ROLE_INDEP && vs_en == 2'h2;
  endproperty
  a_role_three: assert property (p_role_three) else $error("three-phase roles wrong"); // [RULE11]
  property p_role_four;
    @(posedge hclk) disable iff (!hresetn)
      (r.ctrl.mode == frpm_pkg::MODE_FOUR && r.ctrl.dev2) |-> role[0] == frpm_pkg::ROLE_SLAVE1
      && role[1] == frpm_pkg::ROLE_SLAVE3 && vs_en == 2'h0;
  endproperty
  a_role_four: assert property (p_role_four) else $error("four-phase roles wrong"); // [RULE12]
  property p_stat_keep;
    @(posedge hclk) disable iff (!hresetn)
      (|ev_all) |=> (r.stat & $past(ev_all)) == $past(ev_all) ##1 irq == |(r.stat & r.mask);
  endproperty
  a_stat_keep: assert property (p_stat_keep) else $error("event lost from status"); // [RULE3]
endmodule : frpm_top

// [tb/frpm_fault_bus.sv]
// Model of the shared fault wires with their pull-ups and the peer phases on them.
module frpm_fault_bus (
  input wire logic tie,
  input wire logic [1:0] oe,
  input wire logic [1:0] peer_low,
  output logic [1:0] line
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Wire resolution
  // ------------------------------------------------------------
  // A released wire floats up to the pull-up level, so no stale value is ever held.
  logic [1:0] low;
  assign low = oe | peer_low;
  assign line[0] = !(low[0] | (tie & low[1]));
  assign line[1] = !(low[1] | (tie & low[0]));
endmodule : frpm_fault_bus

// [tb/frpm_top_tb_top.sv]
// Self-checking testbench of the fault response and phase role block.
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module frpm_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, von, voff, jhot, jcool, tie;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, oc, fbu, fbo, eth, etc, fl_in, fl_out, fl_oe, ssr, cbc, peer;
  logic [2:0] hsize;
  logic [3:0] ssp, pwm;
  int num_errors = 0;
  int n_tests = 0;
  logic [6:0] r_ctrl [6] = '{7'h00, 7'h10, 7'h20, 7'h60, 7'h30, 7'h70};
  logic [5:0] r_role [6] = '{6'h00, 6'h08, 6'h10, 6'h21, 6'h10, 6'h19};
  frpm_top i_frpm_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .soft_start_phase(ssp),
    .current_sense_over(oc), .feedback_input_under(fbu), .feedback_input_over(fbo),
    .ext_temp_sense_input_hot(eth), .ext_temp_sense_input_cool(etc),
    .input_on_threshold_hit(von), .input_off_threshold_hit(voff),
    .junction_overtemp_fault(jhot), .junction_cool(jcool), .fault_line_in(fl_in),
    .fault_line_out(fl_out), .fault_line_oe(fl_oe), .pwm_state(pwm),
    .soft_start_req(ssr), .cbc_limit(cbc), .irq(irq));
  frpm_fault_bus i_frpm_fault_bus (.tie(tie), .oe(fl_oe), .peer_low(peer), .line(fl_in));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  task automatic rdy();
    for (int k = 0; k < 20; k++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    num_errors++;
    close_out();
  endtask : rdy
  // The master waits on hready rather than assuming zero wait states.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask : bus
  task automatic wpwm(input int ch, input logic [1:0] v, input int lim);
    for (int k = 0; k < lim; k++) begin
      @(posedge hclk);
      #1;
      if (pwm[ch*2+:2] === v) begin
        n_tests++;
        return;
      end
    end
    $display("CHECK FAILED t=%0t got %h exp %h", $time, pwm, v);
    num_errors++;
    close_out();
  endtask : wpwm
  // ------------------------------------------------------------
  // Clock and main sequence
  // ------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, oc, fbu, fbo, eth, voff, jhot} = '0;
    {tie, peer} = '0;
    hsize = frpm_pkg::HSIZE_WORD;
    ssp = 4'ha;
    etc = 2'h3;
    von = 1'b1;
    jcool = 1'b1;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    `CHK(pwm, 4'h0)
    bus(1'b0, frpm_pkg::A_VIEW, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b0, 8'h40, 32'h0);
    `CHK(q, 32'h0)
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, frpm_pkg::A_CTRL, {25'h0, r_ctrl[i]});
      bus(1'b0, frpm_pkg::A_VIEW, 32'h0);
      `CHK(q[15:10], r_role[i])
      `CHK(hresp, 1'b0)
    end
    $display("test roles done");
    bus(1'b1, frpm_pkg::A_CTRL, 32'h1);
    wpwm(0, frpm_pkg::PWM_RUN, 50);
    @(posedge hclk);
    ssp <= 4'h9;
    oc <= 2'h1;
    repeat (8) @(posedge hclk);
    #1;
    `CHK(cbc[0], 1'b1)
    `CHK(pwm[1:0], frpm_pkg::PWM_RUN)
    @(posedge hclk);
    oc <= 2'h0;
    fbo <= 2'h1;
    wpwm(0, frpm_pkg::PWM_LOW, 20);
    bus(1'b1, frpm_pkg::A_MASK, 32'h1 << frpm_pkg::EV_OV);
    repeat (2) @(posedge hclk);
    #1;
    `CHK(irq, 1'b1)
    @(posedge hclk);
    fbo <= 2'h0;
    ssp <= 4'ha;
    bus(1'b1, frpm_pkg::A_STAT, 32'h3fff);
    repeat (2) @(posedge hclk);
    #1;
    `CHK(irq, 1'b0)
    `CHK(pwm[1:0], frpm_pkg::PWM_LOW)
    bus(1'b1, frpm_pkg::A_CTRL, 32'h0);
    wpwm(0, frpm_pkg::PWM_TRI, 20);
    $display("test overvoltage done");
    bus(1'b1, frpm_pkg::A_CTRL, 32'h1);
    wpwm(0, frpm_pkg::PWM_RUN, 50);
    @(posedge hclk);
    peer <= 2'h1;
    wpwm(0, frpm_pkg::PWM_TRI, 20);
    `CHK(fl_oe[0], 1'b0)
    bus(1'b0, frpm_pkg::A_STAT, 32'h0);
    `CHK(q[frpm_pkg::EV_EXT], 1'b1)
    @(posedge hclk);
    peer <= 2'h0;
    wpwm(0, frpm_pkg::PWM_RUN, 50);
    bus(1'b1, frpm_pkg::A_STAT, 32'h3fff);
    $display("test external fault done");
    bus(1'b1, frpm_pkg::A_CTRL, 32'h0);
    @(posedge hclk);
    tie <= 1'b1;
    bus(1'b1, frpm_pkg::A_CTRL, 32'h13);
    wpwm(1, frpm_pkg::PWM_RUN, 50);
    @(posedge hclk);
    ssp <= 4'h9;
    fbu <= 2'h1;
    repeat (10) @(posedge hclk);
    #1;
    `CHK(pwm[1:0], frpm_pkg::PWM_RUN)
    @(posedge hclk);
    ssp <= 4'ha;
    wpwm(0, frpm_pkg::PWM_TRI, 20);
    `CHK(fl_oe[0], 1'b1)
    `CHK(fl_out, 2'h0)
    wpwm(1, frpm_pkg::PWM_TRI, 10);
    @(posedge hclk);
    fbu <= 2'h0;
    repeat (600) @(posedge hclk);
    #1;
    `CHK(pwm, 4'h0)
    wpwm(0, frpm_pkg::PWM_RUN, 300);
    $display("test hiccup done");
    bus(1'b1, frpm_pkg::A_CTRL, 32'h0);
    @(posedge hclk);
    tie <= 1'b0;
    bus(1'b1, frpm_pkg::A_CTRL, 32'h2);
    wpwm(1, frpm_pkg::PWM_RUN, 50);
    @(posedge hclk);
    eth <= 2'h2;
    etc <= 2'h1;
    wpwm(1, frpm_pkg::PWM_TRI, 20);
    @(posedge hclk);
    eth <= 2'h0;
    etc <= 2'h3;
    wpwm(1, frpm_pkg::PWM_RUN, 1000);
    $display("test temperature done");
    bus(1'b1, frpm_pkg::A_CTRL, 32'h5);
    wpwm(0, frpm_pkg::PWM_RUN, 50);
    @(posedge hclk);
    oc <= 2'h1;
    repeat (1000) @(posedge hclk);
    #1;
    `CHK(pwm[1:0], frpm_pkg::PWM_RUN)
    wpwm(0, frpm_pkg::PWM_TRI, 600);
    @(posedge hclk);
    oc <= 2'h0;
    repeat (800) @(posedge hclk);
    #1;
    `CHK(pwm[1:0], frpm_pkg::PWM_TRI)
    bus(1'b0, frpm_pkg::A_STAT, 32'h0);
    `CHK(q[frpm_pkg::EV_OC], 1'b1)
    $display("test current latch done");
    bus(1'b1, frpm_pkg::A_CTRL, 32'h0);
    bus(1'b1, frpm_pkg::A_CTRL, 32'h9);
    wpwm(0, frpm_pkg::PWM_RUN, 50);
    @(posedge hclk);
    ssp <= 4'h9;
    fbo <= 2'h1;
    repeat (10) @(posedge hclk);
    #1;
    `CHK(pwm[1:0], frpm_pkg::PWM_RUN)
    @(posedge hclk);
    {ssp, fbo, jhot, jcool} <= {4'h0, 2'h0, 2'h2};
    wpwm(0, frpm_pkg::PWM_TRI, 20);
    @(posedge hclk);
    jhot <= 1'b0;
    repeat (20) @(posedge hclk);
    #1;
    `CHK(pwm[1:0], frpm_pkg::PWM_TRI)
    @(posedge hclk);
    {ssp, jcool} <= {4'ha, 1'b1};
    wpwm(0, frpm_pkg::PWM_RUN, 50);
    `CHK(ssr[0], 1'b1)
    @(posedge hclk);
    {von, voff} <= 2'h1;
    wpwm(0, frpm_pkg::PWM_TRI, 20);
    repeat (750) @(posedge hclk);
    #1;
    `CHK(pwm[1:0], frpm_pkg::PWM_TRI)
    @(posedge hclk);
    {von, voff} <= 2'h2;
    wpwm(0, frpm_pkg::PWM_RUN, 50);
    $display("test junction and supply done");
    close_out();
  end
endmodule : frpm_top_tb_top
